// ---- rtl/lvd_reset_ctrl.v ----
// Low-voltage detect and reset controller with an AXI4-Lite register port.
// Assumes comparator outputs and the reset pin are asynchronous; the
// power-on and watchdog resets arrive synchronously on rst and wdtReset.
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "lvd_consts.vh"

// Operation
// - Detect enable gates every detection function.
// - Reserved bits read one, ignore writes.
// - Control bit three selects reset level.
// - Control bit two enables undervolt reset.
// - Control bit one enables fall interrupt.
// - Control bit zero enables rise interrupt.
// - Detect, level and reset-enable bits survive undervolt reset only; the code also keeps them over the reset pin.
// - Flag clears by zero after read one.
// - Rise flag needs armed prior fall.
// - Undervolt reset clears both flags.
// - Reset pin holds prescaler; then counts.
// - Low supply asserts reset, holds prescaler.
// - Prescaler recounts after supply recovers.
// - Fall drives interrupt low, sets flag.
// - Rise drives interrupt high, sets flag.
module lvd_reset_ctrl #(
  parameter PRESCALE = `LVD_PRESCALE_COUNT
) (
  input  wire        mclk,              // System clock, 100 MHz.
  input  wire        rst,               // Power-on reset, active high.
  input  wire        wdtReset,          // Watchdog reset, active high.
  input  wire        resetPinN,         // Filtered reset pin, low holds.
  input  wire        belowFall,         // Supply below fall level.
  input  wire        aboveRise,         // Supply above rise level.
  input  wire        belowResetLow,     // Supply below low reset level.
  input  wire        belowResetHigh,    // Supply below high reset level.
  output wire        undervoltResetN,   // Undervolt reset, active low.
  output wire        undervoltIntN,     // Undervolt interrupt, active low.
  output wire        internalResetN,    // Chip reset, active low.
  output reg         extInterruptLine0, // Interrupt line 0 request pulse.
  input  wire [3:0]  s_axi_awaddr,      // Write address.
  input  wire        s_axi_awvalid,     // Write address valid.
  output wire        s_axi_awready,     // Write address ready.
  input  wire [31:0] s_axi_wdata,       // Write data.
  input  wire [3:0]  s_axi_wstrb,       // Write strobes.
  input  wire        s_axi_wvalid,      // Write data valid.
  output wire        s_axi_wready,      // Write data ready.
  output reg  [1:0]  s_axi_bresp,       // Write response.
  output reg         s_axi_bvalid,      // Write response valid.
  input  wire        s_axi_bready,      // Write response ready.
  input  wire [3:0]  s_axi_araddr,      // Read address.
  input  wire        s_axi_arvalid,     // Read address valid.
  output wire        s_axi_arready,     // Read address ready.
  output reg  [31:0] s_axi_rdata,       // Read data.
  output reg  [1:0]  s_axi_rresp,       // Read response.
  output reg         s_axi_rvalid,      // Read data valid.
  input  wire        s_axi_rready       // Read response ready.
);

  // Synchronised comparator and pin levels.
  wire [4:0] syncIn;
  wire       pinLowS;
  wire       fallS;
  wire       riseS;
  wire       rstLowS;
  wire       rstHighS;

  // Control and flag state.
  reg        detectEnable;
  reg        resetLevelSelect;
  reg        undervoltResetEnable;
  reg        fallIrqEnable;
  reg        riseIrqEnable;
  reg        fallFlag;
  reg        riseFlag;
  reg        fallReadOne;
  reg        riseReadOne;
  reg        undervoltActive;
  reg        intLow;
  reg        armedRise;
  reg        fallPrev;
  reg        risePrev;

  // Bus state.
  reg        awHeld;
  reg        wHeld;
  reg [3:0]  awAddr;
  reg [7:0]  wByte;
  reg        wLane;

  wire       belowReset;
  wire       fallEdge;
  wire       riseEdge;
  wire       prescalerHold;
  wire       overflow;
  wire       writeGo;
  wire       readGo;
  wire       softReset;
  wire       clrFall;
  wire       clrRise;
  wire [7:0] ctrlValue;
  wire [7:0] flagValue;

  lvd_sync #(
    .WIDTH (5)
  ) u_sync (
    .mclk   (mclk),
    .rst    (rst),
    .async  ({~resetPinN, belowFall, aboveRise, belowResetLow,
              belowResetHigh}),
    .synced (syncIn)
  );

  assign pinLowS  = syncIn[4];
  assign fallS    = syncIn[3];
  assign riseS    = syncIn[2];
  assign rstLowS  = syncIn[1];
  assign rstHighS = syncIn[0];

  // level select
  // Pick the comparator that matches the selected reset level.
  assign belowReset = resetLevelSelect ? rstHighS : rstLowS;

  // detect gating
  // Edges of the gated comparators drive the detection events.
  assign fallEdge = detectEnable & fallS & ~fallPrev;
  assign riseEdge = detectEnable & riseS & ~risePrev & intLow;

  // Chip-level soft resets: power-on and watchdog.
  assign softReset = rst | wdtReset;

  // reset assertion
  // Drive the undervolt reset from the latched low-supply state.
  assign undervoltResetN = ~undervoltActive;
  assign undervoltIntN   = ~intLow;

  // pin hold
  // Any reset source keeps the prescaler cleared.
  assign prescalerHold = softReset | pinLowS | undervoltActive;
  assign internalResetN = overflow;

  // prescaler recount
  // The prescaler restarts whenever the hold drops away.
  lvd_prescaler #(
    .COUNT (PRESCALE),
    .CW    (18)
  ) u_prescaler (
    .mclk     (mclk),
    .hold     (prescalerHold),
    .overflow (overflow)
  );

  // Track comparator history for edge detection.
  always @(posedge mclk) begin
    if (rst) begin
      fallPrev <= 1'b0;
      risePrev <= 1'b0;
    end else begin
      fallPrev <= fallS;
      risePrev <= riseS;
    end
  end

  // Undervolt reset latch, cleared once supply is back above the level.
  always @(posedge mclk) begin
    if (softReset) begin
      undervoltActive <= 1'b0;
    end else if (detectEnable && undervoltResetEnable && belowReset) begin
      undervoltActive <= 1'b1;
    end else if (!belowReset) begin
      undervoltActive <= 1'b0;
    end
  end

  // fall event
  // Interrupt level and request pulse follow the fall and rise events.
  always @(posedge mclk) begin
    if (softReset || undervoltActive) begin
      intLow            <= 1'b0;
      armedRise         <= 1'b0;
      extInterruptLine0 <= 1'b0;
    end else begin
      extInterruptLine0 <= 1'b0;
      if (!detectEnable) begin
        intLow    <= 1'b0;
        armedRise <= 1'b0;
      end else if (fallEdge) begin
        intLow            <= 1'b1;
        armedRise         <= riseIrqEnable;
        extInterruptLine0 <= fallIrqEnable;
      end else if (riseEdge) begin
        intLow            <= 1'b0;
        armedRise         <= 1'b0;
        extInterruptLine0 <= riseIrqEnable;
      end else if (rstLowS) begin
        armedRise <= 1'b0;
      end
    end
  end

  // control retention
  // Enable, level and reset-enable bits ignore the undervolt reset.
  always @(posedge mclk) begin
    if (softReset) begin
      detectEnable         <= 1'b0;
      resetLevelSelect     <= 1'b0;
      undervoltResetEnable <= 1'b0;
    end else if (writeGo && awAddr == `LVD_CTRL_ADDR && wLane) begin
      detectEnable         <= wByte[`LVD_CTRL_DETECT];
      resetLevelSelect     <= wByte[`LVD_CTRL_LEVEL];
      undervoltResetEnable <= wByte[`LVD_CTRL_RSTEN];
    end
  end

  // Interrupt enables reset on power-on, watchdog and undervolt reset, not the reset pin.
  always @(posedge mclk) begin
    if (softReset || undervoltActive) begin
      fallIrqEnable <= 1'b0;
      riseIrqEnable <= 1'b0;
    end else if (writeGo && awAddr == `LVD_CTRL_ADDR && wLane) begin
      fallIrqEnable <= wByte[`LVD_CTRL_FALLIE];
      riseIrqEnable <= wByte[`LVD_CTRL_RISEIE];
    end
  end

  // read-then-clear
  // A zero write clears a flag only after that flag was read as one.
  assign clrFall = writeGo && awAddr == `LVD_FLAGS_ADDR && wLane &&
                   !wByte[`LVD_FLAG_FALL] && fallReadOne;
  assign clrRise = writeGo && awAddr == `LVD_FLAGS_ADDR && wLane &&
                   !wByte[`LVD_FLAG_RISE] && riseReadOne;

  // flag reset
  // Flags clear on power-on, watchdog or undervolt reset; hardware set wins over a clear.
  always @(posedge mclk) begin
    if (softReset || undervoltActive) begin
      fallFlag    <= 1'b0;
      riseFlag    <= 1'b0;
      fallReadOne <= 1'b0;
      riseReadOne <= 1'b0;
    end else begin
      if (fallEdge) begin
        fallFlag <= 1'b1;
      end else if (clrFall) begin
        fallFlag <= 1'b0;
      end
      if (riseEdge && armedRise && riseIrqEnable) begin
        riseFlag <= 1'b1;
      end else if (clrRise) begin
        riseFlag <= 1'b0;
      end
      if (readGo && s_axi_araddr == `LVD_FLAGS_ADDR) begin
        fallReadOne <= fallFlag;
        riseReadOne <= riseFlag;
      end else if (clrFall || clrRise) begin
        fallReadOne <= 1'b0;
        riseReadOne <= 1'b0;
      end
    end
  end

  // reserved ones
  // Reserved bits are constant ones in the read values.
  assign ctrlValue = `LVD_CTRL_RSVD |
                     {detectEnable, 3'h0, resetLevelSelect,
                      undervoltResetEnable, fallIrqEnable, riseIrqEnable};
  assign flagValue = `LVD_FLAG_RSVD | {6'h00, fallFlag, riseFlag};

  // Write channel: accept address and data separately, then answer.
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign writeGo       = awHeld && wHeld && !s_axi_bvalid;

  always @(posedge mclk) begin
    if (rst) begin
      awHeld       <= 1'b0;
      wHeld        <= 1'b0;
      awAddr       <= 4'h0;
      wByte        <= 8'h00;
      wLane        <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `LVD_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wByte <= s_axi_wdata[7:0];
        wLane <= s_axi_wstrb[0];
      end
      if (writeGo) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr == `LVD_CTRL_ADDR ||
                         awAddr == `LVD_FLAGS_ADDR) ?
                        `LVD_RESP_OKAY : `LVD_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one read at a time, answered the next cycle.
  assign s_axi_arready = !s_axi_rvalid;
  assign readGo        = s_axi_arvalid && s_axi_arready;

  always @(posedge mclk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `LVD_RESP_OKAY;
    end else if (readGo) begin
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr == `LVD_CTRL_ADDR) begin
        s_axi_rdata <= {24'h000000, ctrlValue};
        s_axi_rresp <= `LVD_RESP_OKAY;
      end else if (s_axi_araddr == `LVD_FLAGS_ADDR) begin
        s_axi_rdata <= {24'h000000, flagValue};
        s_axi_rresp <= `LVD_RESP_OKAY;
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `LVD_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/lvd_consts.vh ----
// Constants for the low-voltage detect and reset controller.
// Assumes a 100 MHz system clock and an AXI4-Lite register port.
`ifndef LVD_CONSTS_VH
`define LVD_CONSTS_VH

// Register byte offsets on the register bus.
`define LVD_CTRL_ADDR      4'h0
`define LVD_FLAGS_ADDR     4'h4

// Control register fields.
`define LVD_CTRL_DETECT    7
`define LVD_CTRL_LEVEL     3
`define LVD_CTRL_RSTEN     2
`define LVD_CTRL_FALLIE    1
`define LVD_CTRL_RISEIE    0
`define LVD_CTRL_RSVD      8'h70

// Flag register fields.
`define LVD_FLAG_FALL      1
`define LVD_FLAG_RISE      0
`define LVD_FLAG_RSVD      8'hfc

// Prescaler count before the internal reset is released.
`define LVD_PRESCALE_COUNT 131072

// AXI response codes.
`define LVD_RESP_OKAY      2'h0
`define LVD_RESP_SLVERR    2'h2

`endif

// ---- rtl/lvd_sync.v ----
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes the inputs come from analog comparators or pins.
`timescale 1ns/1ps
`default_nettype none

module lvd_sync #(
  parameter WIDTH = 4
) (
  input  wire             mclk,   // System clock.
  input  wire             rst,    // Synchronous reset, active high.
  input  wire [WIDTH-1:0] async,  // Raw levels.
  output reg  [WIDTH-1:0] synced  // Levels in the clock domain.
);

  reg [WIDTH-1:0] stage1;

  // The first stage feeds only the second stage.
  always @(posedge mclk) begin
    if (rst) begin
      stage1 <= {WIDTH{1'b0}};
      synced <= {WIDTH{1'b0}};
    end else begin
      stage1 <= async;
      synced <= stage1;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/lvd_prescaler.v ----
// Reset prescaler that counts after every reset source is released.
// Assumes its hold input is already synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
`include "lvd_consts.vh"

module lvd_prescaler #(
  parameter COUNT = `LVD_PRESCALE_COUNT,
  parameter CW    = 18
) (
  input  wire mclk,      // System clock.
  input  wire hold,      // Keeps the counter cleared while high.
  output reg  overflow   // Sticks high once the count completes.
);

  reg [CW-1:0] count;

  // Count up while not held; overflow releases the internal reset.
  always @(posedge mclk) begin
    if (hold) begin
      count    <= {CW{1'b0}};
      overflow <= 1'b0;
    end else if (!overflow) begin
      if (count == COUNT[CW-1:0] - 1'b1) begin
        overflow <= 1'b1;
      end
      count <= count + 1'b1;
    end
  end

endmodule

`default_nettype wire

// ---- testbench/lvd_reset_ctrl_monitor.sv ----
// Port checker for the low-voltage detect and reset controller.
// Assumes it is bound into every instance of lvd_reset_ctrl.
`timescale 1ns/1ps
`default_nettype none
module lvd_reset_ctrl_monitor #(
  parameter PRESCALE = 131072
) (
  input wire        mclk,              // System clock.
  input wire        rst,               // Reset, active high.
  input wire        wdtReset,          // Watchdog reset.
  input wire        resetPinN,         // Reset pin.
  input wire        undervoltResetN,   // Undervolt reset.
  input wire        undervoltIntN,     // Undervolt interrupt.
  input wire        internalResetN,    // Chip reset.
  input wire        extInterruptLine0, // Interrupt pulse.
  input wire        s_axi_awvalid,     // Write address valid.
  input wire        s_axi_awready,     // Write address ready.
  input wire        s_axi_wvalid,      // Write data valid.
  input wire        s_axi_wready,      // Write data ready.
  input wire        s_axi_bvalid,      // Write response valid.
  input wire        s_axi_bready,      // Write response ready.
  input wire        s_axi_arvalid,     // Read address valid.
  input wire        s_axi_arready,     // Read address ready.
  input wire        s_axi_rvalid,      // Read data valid.
  input wire        s_axi_rready,      // Read data ready.
  input wire [31:0] s_axi_rdata,       // Read data.
  input wire [1:0]  s_axi_rresp        // Read response.
);
  integer run;

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // Counts clean cycles since any reset hold was last seen.
  always @(posedge mclk) begin
    if (rst || wdtReset || !resetPinN || !undervoltResetN) begin
      run <= 0;
    end else if (run < PRESCALE + 8) begin
      run <= run + 1;
    end
  end

  property p_rst_idle;
    disable iff (1'b0)
    rst |=> undervoltResetN && undervoltIntN && !internalResetN
      && !extInterruptLine0;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("outputs active during reset");

  property p_pulse_one;
    extInterruptLine0 |=> !extInterruptLine0;
  endproperty
  a_pulse_one: assert property (p_pulse_one)
    else $error("interrupt request longer than one cycle");

  property p_uvr_hold;
    !undervoltResetN [*4] |-> !internalResetN;
  endproperty
  a_uvr_hold: assert property (p_uvr_hold)
    else $error("chip reset released during undervolt reset");

  property p_wdt;
    wdtReset |-> ##[1:3] !internalResetN;
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("watchdog reset did not reset the chip");

  property p_run_min;
    $rose(internalResetN) |-> run >= PRESCALE;
  endproperty
  a_run_min: assert property (p_run_min)
    else $error("chip reset released before prescaler count");

  property p_run_max;
    run == PRESCALE + 6 |-> internalResetN;
  endproperty
  a_run_max: assert property (p_run_max)
    else $error("chip reset not released after prescaler count");

  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer late");

  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat)
    else $error("write answer late");

  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");

  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data changed before taken");
endmodule

bind lvd_reset_ctrl lvd_reset_ctrl_monitor #(.PRESCALE(PRESCALE)) u_mon (
  .mclk, .rst, .wdtReset, .resetPinN, .undervoltResetN, .undervoltIntN,
  .internalResetN, .extInterruptLine0, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .s_axi_rresp
);
`default_nettype wire

// ---- testbench/lvd_supply_model.sv ----
// Comparator and reset-pin model facing the controller.
// Assumes the bench sets the supply level in steps of 10 mV.
`timescale 1ns/1ps
`default_nettype none
module lvd_supply_model (
  input  wire [9:0] supply,         // Supply level in 10 mV steps.
  input  wire       pinLow,         // Holds the reset pin low.
  output wire       resetPinN,      // Filtered reset pin.
  output wire       belowFall,      // Below fall level.
  output wire       aboveRise,      // Above rise level.
  output wire       belowResetLow,  // Below low reset level.
  output wire       belowResetHigh  // Below high reset level.
);
  assign resetPinN = !pinLow;
  assign belowFall      = supply < 10'h172;
  assign aboveRise      = supply > 10'h190;
  assign belowResetLow  = supply < 10'he6;
  assign belowResetHigh = supply < 10'h168;
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the low-voltage detect and reset controller.
// Assumes the comparator model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
`include "lvd_consts.vh"
module testbench;
  localparam PS = 16;
  logic        mclk, rst, wdtReset, pinLow, s_axi_awvalid, s_axi_wvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [9:0]  supply;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, rdv;
  logic [1:0]  rsp;
  wire         resetPinN, belowFall, aboveRise, belowResetLow;
  wire         belowResetHigh, undervoltResetN, undervoltIntN;
  wire         internalResetN, extInterruptLine0, s_axi_awready;
  wire         s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  integer      badCount = 0, checks = 0, pulses = 0, p;

  lvd_supply_model u_model (.supply, .pinLow, .resetPinN,
    .belowFall, .aboveRise, .belowResetLow, .belowResetHigh);
  lvd_reset_ctrl #(.PRESCALE(PS)) u_dut (.mclk, .rst, .wdtReset, .resetPinN,
    .belowFall, .aboveRise, .belowResetLow, .belowResetHigh,
    .undervoltResetN, .undervoltIntN, .internalResetN, .extInterruptLine0,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  // Free-running clock and interrupt request counter.
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (extInterruptLine0 === 1'b1) pulses <= pulses + 1;
  end

  task finish_test;
    begin
      $display("checks %0d mismatches %0d", checks, badCount);
      if (badCount == 0 && checks > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask

  task chk(input string what, input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        badCount = badCount + 1;
        $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  task tick(input integer n);
    repeat (n) @(posedge mclk);
  endtask

  // Bus write; the response ready rises once both valids have dropped, in the same cycle as the response valid.
  // Waits for the answer however long it takes; only the watchdog ends it.
  task wr(input [3:0] a, input [7:0] d, input [3:0] s);
    begin
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      forever begin
        @(posedge mclk);
        if (s_axi_bready && s_axi_bvalid) break;
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (!s_axi_awvalid && !s_axi_wvalid) s_axi_bready <= 1'b1;
      end
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask

  // Bus read into rdv and rsp.
  task rd(input [3:0] a);
    begin
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      forever begin
        @(posedge mclk);
        if (s_axi_rready && s_axi_rvalid) break;
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (!s_axi_arvalid) s_axi_rready <= 1'b1;
      end
      rdv = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask

  task rchk(input [3:0] a, input [31:0] exp);
    begin
      rd(a);
      chk("regRead", rdv, exp);
      chk("readResp", rsp, `LVD_RESP_OKAY);
    end
  endtask

  task sup(input [9:0] v);
    begin
      @(posedge mclk);
      supply <= v;
      tick(8);
    end
  endtask

  // Waits for the chip reset release and checks its delay.
  task wait_run;
    integer n;
    begin
      for (n = 0; n < 200 && internalResetN !== 1'b1; n++) @(posedge mclk);
      chk("runLen", n >= PS && n <= PS + 8, 1);
    end
  endtask

  task t_reset;
    begin
      chk("chipRst", internalResetN, 0);
      wait_run;
      rchk(`LVD_CTRL_ADDR, 32'h70);
      rchk(`LVD_FLAGS_ADDR, 32'hfc);
      @(posedge mclk);
      pinLow <= 1'b1;
      tick(6);
      chk("pinRst", internalResetN, 0);
      pinLow <= 1'b0;
      wait_run;
      $display("test reset done");
    end
  endtask

  task t_regs;
    begin
      wr(`LVD_CTRL_ADDR, 8'h0f, 4'h1);
      chk("wrResp", rsp, `LVD_RESP_OKAY);
      rchk(`LVD_CTRL_ADDR, 32'h7f);
      wr(`LVD_CTRL_ADDR, 8'h00, 4'h0);
      rchk(`LVD_CTRL_ADDR, 32'h7f);
      wr(4'h8, 8'h00, 4'h1);
      chk("badWr", rsp, `LVD_RESP_SLVERR);
      rd(4'h8);
      chk("badRd", rsp, `LVD_RESP_SLVERR);
      wr(`LVD_CTRL_ADDR, 8'h00, 4'h1);
      wr(`LVD_FLAGS_ADDR, 8'hff, 4'h1);
      rchk(`LVD_FLAGS_ADDR, 32'hfc);
      $display("test regs done");
    end
  endtask

  task t_irq;
    begin
      wr(`LVD_CTRL_ADDR, 8'h80, 4'h1);
      tick(5000);
      wr(`LVD_FLAGS_ADDR, 8'h00, 4'h1);
      wr(`LVD_CTRL_ADDR, 8'h83, 4'h1);
      p = pulses;
      sup(10'h16d);
      chk("fallReq", pulses, p + 1);
      chk("intLow", undervoltIntN, 0);
      rchk(`LVD_FLAGS_ADDR, 32'hfe);
      sup(10'h1c2);
      chk("riseReq", pulses, p + 2);
      chk("intHigh", undervoltIntN, 1);
      wr(`LVD_FLAGS_ADDR, 8'h00, 4'h1);
      rchk(`LVD_FLAGS_ADDR, 32'hfd);
      wr(`LVD_FLAGS_ADDR, 8'h00, 4'h1);
      rchk(`LVD_FLAGS_ADDR, 32'hfc);
      wr(`LVD_CTRL_ADDR, 8'h80, 4'h1);
      wr(`LVD_CTRL_ADDR, 8'h00, 4'h1);
      sup(10'h15e);
      chk("offInt", undervoltIntN, 1);
      chk("offRst", undervoltResetN, 1);
      rchk(`LVD_FLAGS_ADDR, 32'hfc);
      sup(10'h1c2);
      $display("test interrupt done");
    end
  endtask

  task t_lvr;
    begin
      wr(`LVD_CTRL_ADDR, 8'h80, 4'h1);
      tick(5000);
      wr(`LVD_CTRL_ADDR, 8'hec, 4'h1);
      p = pulses;
      sup(10'h16d);
      chk("noFall", pulses, p);
      chk("intLow", undervoltIntN, 0);
      sup(10'h1c2);
      chk("noRise", pulses, p);
      rchk(`LVD_FLAGS_ADDR, 32'hfe);
      sup(10'h15e);
      chk("uvRst", undervoltResetN, 0);
      chk("chipRst", internalResetN, 0);
      rchk(`LVD_FLAGS_ADDR, 32'hfc);
      rchk(`LVD_CTRL_ADDR, 32'hfc);
      supply <= 10'h1c2;
      wait_run;
      rchk(`LVD_CTRL_ADDR, 32'hfc);
      wr(`LVD_CTRL_ADDR, 8'h88, 4'h1);
      rchk(`LVD_CTRL_ADDR, 32'hf8);
      wr(`LVD_CTRL_ADDR, 8'h08, 4'h1);
      rchk(`LVD_CTRL_ADDR, 32'h78);
      $display("test undervolt reset done");
    end
  endtask

  task t_wdt;
    begin
      @(posedge mclk);
      wdtReset <= 1'b1;
      tick(3);
      wdtReset <= 1'b0;
      chk("wdtRst", internalResetN, 0);
      wait_run;
      rchk(`LVD_CTRL_ADDR, 32'h70);
      $display("test watchdog done");
    end
  endtask

  // Main sequence: ten cycles of reset, then each scenario.
  initial begin
    {mclk, wdtReset, pinLow, s_axi_awvalid, s_axi_wvalid} = 0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 0;
    rst = 1'b1;
    supply = 10'h1c2;
    tick(10);
    rst <= 1'b0;
    t_reset;
    t_regs;
    t_irq;
    t_lvr;
    t_wdt;
    finish_test;
  end

  // Cuts a hang short.
  initial begin
    tick(40000);
    badCount = badCount + 1;
    finish_test;
  end
endmodule
`default_nettype wire
